// *** rcf_pkg.sv ***
/*
  rcf_pkg: constants, register map, mode codes and carrier structs for the
  reset-event and configuration-freeze block.
  Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
package rcf_pkg;
  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RCF_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  RCF_OFF_STATUS = 8'h04;
  localparam logic [7:0]  RCF_OFF_FLAGS  = 8'h08;
  localparam logic [7:0]  RCF_OFF_CFG    = 8'h0C;
  // control register bit positions (write-one actions)
  localparam int          RCF_CTRL_ENTER = 0;
  localparam int          RCF_CTRL_LEAVE = 1;
  localparam int          RCF_CTRL_CLRB  = 2;
  // sticky flag bit positions
  localparam int          RCF_FLG_PRST   = 0;
  localparam int          RCF_FLG_PCER   = 1;
  localparam int          RCF_FLG_SCER   = 2;
  localparam int          RCF_FLG_SRST   = 3;
  localparam int          RCF_FLG_CFGERR = 4;
  // reset values
  localparam logic [15:0] RCF_CFG_RST    = 16'h0000;
  localparam logic [4:0]  RCF_FLAGS_RST  = 5'h00;
  localparam logic [31:0] RCF_RDATA_RST  = 32'h0000_0000;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          RCF_CLK_PS      = 5000;
  localparam int          RCF_LIFE_TO_NS  = 1000;
  localparam int          RCF_LIFE_TO_CYC = (RCF_LIFE_TO_NS * 1000) / RCF_CLK_PS;
  localparam logic [7:0]  RCF_LIFE_LAST   = 8'(RCF_LIFE_TO_CYC - 1);
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RCF_DEFAULT = 2'b00,
    RCF_NORMAL  = 2'b01,
    RCF_CONFIG  = 2'b10
  } rcf_mode_t;

  typedef struct packed {
    logic pri_curref_fault;
    logic pri_mem_err;
    logic sec_uvlo;
    logic sec_osc_nostart;
    logic sec_osc_fault;
    logic sec_curref_open;
    logic sec_reg_short;
    logic sec_mem_err;
  } rcf_src_t;

  typedef struct packed {
    rcf_mode_t   mode;
    logic        frozen;
    logic [15:0] cfg;
    logic [15:0] cfg_chk;
    logic [4:0]  flags;
    logic        pri_rst_q;
    logic        sec_any_q;
    logic        uvlo_q;
    logic        fault_b;
    logic [7:0]  life_cnt;
    logic        rst_rdy_n;
    logic        flt_a_n;
    logic        flt_b_n;
    logic        sdo;
    logic        pwm_off;
    logic        shutdown;
    logic        dsat_clamp;
    logic        aclamp;
    logic        sec_uv_n;
    logic        sec_ready;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rcf_state_t;
endpackage : rcf_pkg

// *** rcf_top.sv ***
/*
  rcf_top: reset-event handling, fault pins and static configuration
  freeze for a two-chip isolated gate driver, with an APB register slave.
  Assumes all inputs synchronous to CLOCK and an APB master that holds its
  request until PREADY; every transfer takes one wait state.
*/
`timescale 1ns/1ps
module rcf_top
  import rcf_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire rcf_src_t    SRC,
  input  wire logic        LIFESIGN,
  input  wire logic        SHUTDOWN_IN,
  input  wire logic        SDO_IN,
  input  wire logic        ACLAMP_REQ,
  input  wire logic        CFG_UPSET,
  output logic             RESET_READY_N,
  output logic             FAULT_A_N,
  output logic             FAULT_B_N,
  output logic             SDO,
  output logic             PWM_OFF,
  output logic             SHUTDOWN,
  output logic             DSAT_CLAMP,
  output logic             ACLAMP,
  output logic             SEC_UV_N,
  output logic             SEC_READY
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // address match on word-aligned byte offsets
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  rcf_state_t s;
  rcf_state_t next_s;

  logic pri_rst;
  logic sec_hard;
  logic sec_any;
  logic cer_src;
  logic cfg_bad;
  logic any_reset;
  logic access;
  logic commit;
  logic wr_cfg;

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  // consistency check compares the stored word with its inverted copy
  assign cfg_bad   = (s.cfg != ~s.cfg_chk);
  assign pri_rst   = SRC.pri_curref_fault | SRC.pri_mem_err | cfg_bad;
  assign sec_hard  = SRC.sec_uvlo | SRC.sec_osc_nostart | SRC.sec_curref_open
                   | SRC.sec_mem_err;
  assign sec_any   = sec_hard | SRC.sec_osc_fault | SRC.sec_reg_short;
  // the open reference is the one secondary source without comm error
  assign cer_src   = SRC.sec_uvlo | SRC.sec_osc_nostart | SRC.sec_osc_fault
                   | SRC.sec_reg_short | SRC.sec_mem_err;
  assign any_reset = pri_rst | sec_any;
  // one wait state: data captured in the first access cycle, effect at the second
  assign access    = PSEL & PENABLE & ~s.pready;
  assign commit    = PSEL & PENABLE & s.pready & PWRITE;
  assign wr_cfg    = commit & hit(PADDR, RCF_OFF_CFG);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] flg_set;
    logic [4:0] flg_clr;
    flg_set = 5'h00;
    flg_clr = 5'h00;
    next_s  = s;

    // edge memories for event ends and starts
    next_s.pri_rst_q = pri_rst;
    next_s.sec_any_q = sec_any;
    next_s.uvlo_q    = SRC.sec_uvlo;

    // reset flag is set only when the primary source has gone away
    if (s.pri_rst_q && !pri_rst) begin
      flg_set[RCF_FLG_PRST] = 1'b1;
    end
    // comm error only from secondary sources, never from primary ones
    if (sec_any && !s.sec_any_q && cer_src) begin
      flg_set[RCF_FLG_PCER] = 1'b1;
    end
    if (s.uvlo_q && !SRC.sec_uvlo) begin
      flg_set[RCF_FLG_SRST] = 1'b1;
    end
    if (cfg_bad) begin
      flg_set[RCF_FLG_CFGERR] = 1'b1;
    end

    // lifesign watchdog runs only while the primary is held in reset
    if (!pri_rst || LIFESIGN) begin
      next_s.life_cnt = 8'h00;
    end else if (s.life_cnt == RCF_LIFE_LAST) begin
      flg_set[RCF_FLG_SCER] = 1'b1;
    end else begin
      next_s.life_cnt = s.life_cnt + 8'h01;
    end

    // class-B latch: end of primary reset, start of a secondary event
    if ((s.pri_rst_q && !pri_rst) || (sec_any && !s.sec_any_q) || cfg_bad) begin
      next_s.fault_b = 1'b1;
    end else if (commit && hit(PADDR, RCF_OFF_CTRL) && PWDATA[RCF_CTRL_CLRB]) begin
      next_s.fault_b = 1'b0;
    end

    // mode and static configuration
    if (any_reset) begin
      next_s.mode    = RCF_DEFAULT;
      next_s.frozen  = 1'b0;
      next_s.cfg     = RCF_CFG_RST;
      next_s.cfg_chk = ~RCF_CFG_RST;
    end else begin
      if (commit && hit(PADDR, RCF_OFF_CTRL)) begin
        unique case (s.mode)
          RCF_DEFAULT: begin
            if (PWDATA[RCF_CTRL_ENTER]) begin
              next_s.mode = RCF_CONFIG;
            end
          end
          RCF_CONFIG: begin
            if (PWDATA[RCF_CTRL_LEAVE]) begin
              next_s.mode   = RCF_NORMAL;
              next_s.frozen = 1'b1;
            end
          end
          RCF_NORMAL: begin
            next_s.mode = RCF_NORMAL;
          end
          default: begin
            next_s.mode = RCF_DEFAULT;
          end
        endcase
      end
      // frozen or outside configuration mode the write is dropped
      if (wr_cfg && s.mode == RCF_CONFIG && !s.frozen) begin
        next_s.cfg     = PWDATA[15:0];
        next_s.cfg_chk = ~PWDATA[15:0];
      end
      // models a storage upset so the check can be exercised
      if (CFG_UPSET) begin
        next_s.cfg_chk[0] = ~s.cfg_chk[0];
      end
    end

    // sticky flags: write-one-to-clear, a new event wins over the clear
    if (commit && hit(PADDR, RCF_OFF_FLAGS)) begin
      flg_clr = PWDATA[4:0];
    end
    next_s.flags = (s.flags & ~flg_clr) | flg_set;

    // pin levels, all registered
    next_s.rst_rdy_n  = ~pri_rst;
    next_s.flt_a_n    = 1'b1;
    next_s.flt_b_n    = ~(next_s.fault_b | pri_rst);
    next_s.sdo        = pri_rst ? 1'b0 : SDO_IN;
    next_s.pwm_off    = any_reset;
    next_s.shutdown   = SHUTDOWN_IN & ~(SRC.sec_curref_open | SRC.sec_reg_short);
    next_s.dsat_clamp = sec_hard;
    // clamping is off by default, so its control idles high in hard reset
    next_s.aclamp     = sec_hard | ACLAMP_REQ;
    next_s.sec_uv_n   = ~(sec_hard | SRC.sec_reg_short);
    next_s.sec_ready  = ~sec_any;

    // APB slave answer
    next_s.pready  = access;
    next_s.pslverr = 1'b0;
    if (access) begin
      next_s.prdata = RCF_RDATA_RST;
      if (hit(PADDR, RCF_OFF_STATUS)) begin
        next_s.prdata[5:0] = {cfg_bad, s.sec_ready, s.pri_rst_q, s.frozen, s.mode};
      end else if (hit(PADDR, RCF_OFF_FLAGS)) begin
        next_s.prdata[4:0] = s.flags;
      end else if (hit(PADDR, RCF_OFF_CFG)) begin
        next_s.prdata[15:0] = s.cfg;
      end else if (!hit(PADDR, RCF_OFF_CTRL)) begin
        next_s.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s            <= '0;
      s.mode       <= RCF_DEFAULT;
      s.cfg        <= RCF_CFG_RST;
      s.cfg_chk    <= ~RCF_CFG_RST;
      s.flags      <= RCF_FLAGS_RST;
      s.rst_rdy_n  <= 1'b0;
      s.flt_a_n    <= 1'b1;
      s.flt_b_n    <= 1'b1;
      s.pwm_off    <= 1'b1;
      s.sec_uv_n   <= 1'b1;
      s.prdata     <= RCF_RDATA_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign PRDATA        = s.prdata;
  assign PREADY        = s.pready;
  assign PSLVERR       = s.pslverr;
  assign RESET_READY_N = s.rst_rdy_n;
  assign FAULT_A_N     = s.flt_a_n;
  assign FAULT_B_N     = s.flt_b_n;
  assign SDO           = s.sdo;
  assign PWM_OFF       = s.pwm_off;
  assign SHUTDOWN      = s.shutdown;
  assign DSAT_CLAMP    = s.dsat_clamp;
  assign ACLAMP        = s.aclamp;
  assign SEC_UV_N      = s.sec_uv_n;
  assign SEC_READY     = s.sec_ready;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_rst_flag;
    $rose(RESET_READY_N) && !$past(SRST, 2) |-> s.flags[RCF_FLG_PRST] && !FAULT_B_N;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag or class-B missing");

  property p_no_pcer;
    !sec_any |=> !$rose(s.flags[RCF_FLG_PCER]);
  endproperty
  a_no_pcer: assert property (p_no_pcer) else $error("comm error set without secondary");

  property p_fltb_end;
    (pri_rst && !sec_any) ##1 !pri_rst |-> ##1 !FAULT_B_N [*2];
  endproperty
  a_fltb_end: assert property (p_fltb_end) else $error("class-B not held after reset");

  property p_life;
    pri_rst && !LIFESIGN && s.life_cnt == RCF_LIFE_LAST |=> s.flags[RCF_FLG_SCER];
  endproperty
  a_life: assert property (p_life) else $error("lifesign loss not flagged");

  property p_pwm;
    any_reset |=> PWM_OFF;
  endproperty
  a_pwm: assert property (p_pwm) else $error("output stage not off");

  property p_shut;
    !SRC.sec_curref_open && !SRC.sec_reg_short |=> $past(SRST) || SHUTDOWN == $past(SHUTDOWN_IN);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown input not followed");

  property p_sdo;
    !pri_rst |=> $past(SRST) || SDO == $past(SDO_IN);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial data not passed through");

  // only a software clear on the flags register may drop a sticky bit
  property p_sticky;
    !(commit && hit(PADDR, RCF_OFF_FLAGS)) |=> (s.flags & $past(s.flags)) == $past(s.flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped");

  property p_ready;
    (SRC.sec_uvlo || SRC.sec_osc_fault) |=> !SEC_READY && !s.sec_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("secondary ready not cleared");

  property p_pcer;
    !s.sec_any_q && !sec_any ##1 (SRC.sec_uvlo || SRC.sec_mem_err)
      |=> s.flags[RCF_FLG_PCER] && !FAULT_B_N && DSAT_CLAMP;
  endproperty
  a_pcer: assert property (p_pcer) else $error("secondary fault not notified");

  property p_mode;
    any_reset |=> s.mode == RCF_DEFAULT && s.cfg == RCF_CFG_RST;
  endproperty
  a_mode: assert property (p_mode) else $error("reset did not restore default mode");

  property p_pins;
    pri_rst |=> !SDO && !FAULT_B_N && FAULT_A_N && !RESET_READY_N;
  endproperty
  a_pins: assert property (p_pins) else $error("primary reset pin levels wrong");

  property p_hard;
    sec_hard |=> DSAT_CLAMP && ACLAMP && !SEC_UV_N;
  endproperty
  a_hard: assert property (p_hard) else $error("secondary hard reset pins wrong");

  property p_freeze;
    (s.frozen || s.mode != RCF_CONFIG) && !any_reset && !CFG_UPSET |=> $stable(s.cfg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("static configuration changed");

  property p_check;
    cfg_bad |=> !RESET_READY_N && s.flags[RCF_FLG_CFGERR] ##1 !cfg_bad;
  endproperty
  a_check: assert property (p_check) else $error("config check did not reset");

  c_pri_end:  cover property (pri_rst ##1 !pri_rst ##1 !FAULT_B_N);
  c_sec_hard: cover property (sec_hard ##1 DSAT_CLAMP);
  c_leave:    cover property (s.mode == RCF_CONFIG ##1 s.frozen);
  c_cfg_err:  cover property (CFG_UPSET ##1 cfg_bad);

endmodule : rcf_top

// *** rcf_host_model.sv ***
/*
  rcf_host_model: far-side stand-in that sends lifesign pulses and a
  changing serial data stream into the block.
  Assumes the bench clock and a level enable for the lifesign.
*/
`timescale 1ns/1ps
module rcf_host_model
  import rcf_pkg::*;
#(
  parameter int LIFE_PERIOD = 50
) (
  input  wire logic clock,
  input  wire logic life_en,
  output logic      lifesign,
  output logic      sdo_in
);
  // ----------------------------------------------------------------------
  // pulse generator
  // ----------------------------------------------------------------------
  int cnt = 0;
  initial begin
    lifesign = 1'b0;
    sdo_in   = 1'b0;
  end
  // data toggles every cycle so an output stuck at its last value shows up
  always @(posedge clock) begin
    cnt      <= (cnt == LIFE_PERIOD - 1) ? 0 : cnt + 1;
    lifesign <= life_en && (cnt == 0);
    sdo_in   <= ~sdo_in;
  end
endmodule : rcf_host_model

// *** tb_reset_event_and_config_freeze.sv ***
/*
  tb_reset_event_and_config_freeze: APB tasks and event sequences for rcf_top.
  Assumes the design holds its own assertions; the host model gives lifesign.
*/
`timescale 1ns/1ps
module tb_reset_event_and_config_freeze
  import rcf_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  localparam logic [7:0] HARD = 8'h35;   // hard-reset sources
  localparam logic [7:0] BLK  = 8'h06;   // sources that block shutdown
  logic        CLOCK = 1'b0;
  logic        SRST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, rdq;
  logic        PREADY, PSLVERR, rerr, life_en, LIFESIGN, SDO_IN;
  rcf_src_t    SRC = '0;
  logic        CFG_UPSET = 1'b0;
  logic        shut_in = 1'b1;
  logic        aclamp_req = 1'b0;
  logic        RESET_READY_N, FAULT_A_N, FAULT_B_N, SDO, PWM_OFF;
  logic        SHUTDOWN, DSAT_CLAMP, ACLAMP, SEC_UV_N, SEC_READY;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  initial life_en = 1'b1;
  always #2.5 CLOCK = ~CLOCK;
  rcf_host_model host (.clock(CLOCK), .life_en(life_en), .lifesign(LIFESIGN), .sdo_in(SDO_IN));
  rcf_top uut (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SRC(SRC), .LIFESIGN(LIFESIGN), .SHUTDOWN_IN(shut_in), .SDO_IN(SDO_IN),
    .ACLAMP_REQ(aclamp_req),
    .CFG_UPSET(CFG_UPSET), .RESET_READY_N(RESET_READY_N), .FAULT_A_N(FAULT_A_N),
    .FAULT_B_N(FAULT_B_N), .SDO(SDO), .PWM_OFF(PWM_OFF), .SHUTDOWN(SHUTDOWN),
    .DSAT_CLAMP(DSAT_CLAMP), .ACLAMP(ACLAMP), .SEC_UV_N(SEC_UV_N), .SEC_READY(SEC_READY));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick
  // one transfer; waits for PREADY without assuming the wait-state count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (PREADY !== 1'b1) fail_count++;
    rdq = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // enter config, program, read back, leave (host side of the sequence)
  task automatic cfg_seq(input logic [31:0] d);
    wr(RCF_OFF_CTRL, 32'h0000_0001 << RCF_CTRL_ENTER);
    wr(RCF_OFF_CFG, d);
    rd(RCF_OFF_CFG);
    chk(rdq, d);
    wr(RCF_OFF_CTRL, 32'h0000_0001 << RCF_CTRL_LEAVE);
  endtask : cfg_seq
  // clearing by software is the only way the latch and flags drop
  task automatic clr;
    wr(RCF_OFF_CTRL, 32'h0000_0001 << RCF_CTRL_CLRB);
    wr(RCF_OFF_FLAGS, 32'h0000_001F);
    @(negedge CLOCK);
    chk(FAULT_B_N, 1'b1);
    rd(RCF_OFF_FLAGS);
    chk(rdq, 32'h0000_0000);
  endtask : clr
  // primary-side source held long enough for the lifesign watchdog
  task automatic pev(input int k, input logic life, input logic scer);
    @(posedge CLOCK);
    SRC <= rcf_src_t'(8'h01 << k);
    life_en <= life;
    tick(3);
    @(negedge CLOCK);
    chk(RESET_READY_N, 1'b0);
    chk({FAULT_B_N, FAULT_A_N, SDO}, 3'b010);
    chk({PWM_OFF, SHUTDOWN}, 2'b11);
    tick(250);
    SRC <= '0;
    life_en <= 1'b1;
    tick(3);
    @(negedge CLOCK);
    chk({RESET_READY_N, FAULT_B_N}, 2'b10);
    rd(RCF_OFF_FLAGS);
    chk(rdq & 32'h0000_0007, 32'({scer, 2'b01}));
    rd(RCF_OFF_STATUS);
    chk(rdq & 32'h0000_0007, 32'h0000_0000);
    rd(RCF_OFF_CFG);
    chk(rdq, 32'h0000_0000);
    clr();
  endtask : pev
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    tick(5);
    SRST <= 1'b0;
    tick(3);
    @(negedge CLOCK);
    chk({RESET_READY_N, FAULT_A_N, FAULT_B_N, PWM_OFF}, 4'b1110);
    // shutdown and clamp control must follow their inputs outside any event
    @(posedge CLOCK);
    shut_in    <= 1'b0;
    aclamp_req <= 1'b1;
    tick(2);
    @(negedge CLOCK);
    chk({SHUTDOWN, ACLAMP, DSAT_CLAMP}, 3'b010);
    @(posedge CLOCK);
    shut_in    <= 1'b1;
    aclamp_req <= 1'b0;
    rd(RCF_OFF_STATUS);
    chk(rdq, 32'h0000_0010);
    $display("test reset done");
    wr(RCF_OFF_CFG, 32'h0000_AAAA);
    rd(RCF_OFF_CFG);
    chk(rdq, 32'h0000_0000);
    cfg_seq(32'h0000_1234);
    rd(RCF_OFF_STATUS);
    chk(rdq & 32'h0000_0007, 32'h0000_0005);
    wr(RCF_OFF_CFG, 32'h0000_5678);
    rd(RCF_OFF_CFG);
    chk(rdq, 32'h0000_1234);
    chk(rerr, 1'b0);
    rd(8'h10);
    chk(rdq, 32'h0000_0000);
    chk(rerr, 1'b1);
    $display("test config done");
    pev(7, 1'b0, 1'b1);
    cfg_seq(32'h0000_00F0);
    pev(6, 1'b1, 1'b0);
    $display("test primary done");
    cfg_seq(32'h0000_0F00);
    for (int k = 5; k >= 0; k--) begin
      @(posedge CLOCK);
      SRC <= rcf_src_t'(8'h01 << k);
      tick(3);
      @(negedge CLOCK);
      chk({SEC_READY, PWM_OFF, RESET_READY_N}, 3'b011);
      chk(SHUTDOWN, !BLK[k]);
      chk(SEC_UV_N, !(HARD[k] || k == 1));
      if (k != 1) chk({ACLAMP, DSAT_CLAMP}, {2{HARD[k]}});
      chk(FAULT_B_N, 1'b0);
      @(posedge CLOCK);
      SRC <= '0;
      tick(3);
      @(negedge CLOCK);
      chk(SEC_READY, 1'b1);
      rd(RCF_OFF_FLAGS);
      chk(rdq[RCF_FLG_PCER], k != 2);
      chk(rdq[RCF_FLG_SRST], k == 5);
      rd(RCF_OFF_STATUS);
      chk(rdq[1:0], 2'b00);
      clr();
    end
    $display("test secondary done");
    @(posedge CLOCK);
    CFG_UPSET <= 1'b1;
    @(posedge CLOCK);
    CFG_UPSET <= 1'b0;
    tick(3);
    @(negedge CLOCK);
    chk(FAULT_B_N, 1'b0);
    rd(RCF_OFF_FLAGS);
    chk(rdq[RCF_FLG_CFGERR], 1'b1);
    clr();
    $display("test check done");
    test_done();
  end
endmodule : tb_reset_event_and_config_freeze
